// File: design/sfc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none


module sfc_ctrl
    import sfc_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = CHIP_ERASE_CYCLES
) (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            rst,
    // Serial pins from the host.
    input  wire logic            cs_n,
    input  wire logic            sck,
    input  wire logic            si,
    input  wire logic            wp_n,
    // Serial data output pin.
    output logic                 so,
    output logic                 so_oe,
    // Status bits.
    output logic                 busy,
    output logic                 wel,
    output logic [BP_W-1:0]      protect_level,
    output logic                 protect_lock,
    // Array erase control.
    output logic                 erase_req,
    output logic [7:0]           erase_fill
);

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CMD    = 2'b01,
        ST_STREAM = 2'b10,
        ST_IGNORE = 2'b11
    } sfc_state_e;

    sfc_link_if lk ();

    sfc_state_e      state_q;
    sfc_state_e      state_d;
    logic [7:0]      opcode_q;
    logic [7:0]      data_q;
    logic [1:0]      nbytes_q;
    logic            wp_m_q;
    logic            wp_s_q;
    logic            ready_q;
    logic [PU_W-1:0] pu_cnt_q;
    logic            busy_q;
    logic [31:0]     cnt_q;
    logic            wel_q;
    logic            arm_q;
    logic [BP_W-1:0] bp_q;
    logic            lock_q;
    logic            erase_req_q;
    logic [7:0]      erase_fill_q;
    logic [SR_W-1:0] status_w;
    logic [SR_W-1:0] snap_q;
    logic [2:0]      idx_q;
    logic            so_q;
    logic            so_oe_q;
    logic            go;
    logic            one_byte;
    logic            erase_op;
    logic            erase_go;
    logic            set_go;
    logic            clr_go;
    logic            arm_go;
    logic            wr_go;
    logic            wr_permit;
    logic            erase_done;

    // Pin sampling and byte assembly.
    sfc_spi_rx u_rx (
        .clk  (clk),
        .rst  (rst),
        .cs_n (cs_n),
        .sck  (sck),
        .si   (si),
        .lk   (lk.rx)
    );

    // Write-protect pin through two flip-flops.
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_m_q <= 1'b0;
            wp_s_q <= 1'b0;
        end else begin
            wp_m_q <= wp_n;
            wp_s_q <= wp_m_q;
        end
    end

    // Commands other than a status read are refused until supply has settled after reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            pu_cnt_q <= '0;
            ready_q  <= 1'b0;
        end else if (!ready_q) begin
            pu_cnt_q <= pu_cnt_q + 1'b1;
            if (pu_cnt_q == PU_W'(PWRUP_CYCLES - 1)) begin
                ready_q <= 1'b1;
            end
        end
    end

    // Frame tracking; a status read opcode is taken even while busy.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (lk.cs_fall) begin
                    state_d = ST_CMD;
                end
            end
            ST_CMD: begin
                if (lk.cs_rise) begin
                    state_d = ST_IDLE;
                end else if (lk.byte_valid && nbytes_q == 2'h0) begin
                    if (lk.rx_byte == OP_STATUS_READ) begin
                        state_d = ST_STREAM;
                    end else if (busy_q || !ready_q) begin
                        state_d = ST_IGNORE;
                    end
                end
            end
            ST_STREAM, ST_IGNORE: begin
                if (lk.cs_rise) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Opcode, first data byte and a saturating byte count per frame.
    always_ff @(posedge clk) begin
        if (rst) begin
            opcode_q <= 8'h00;
            data_q   <= 8'h00;
            nbytes_q <= 2'h0;
        end else if (lk.cs_fall) begin
            nbytes_q <= 2'h0;
        end else if (lk.byte_valid && state_q == ST_CMD) begin
            if (nbytes_q == 2'h0) begin
                opcode_q <= lk.rx_byte;
            end
            if (nbytes_q == 2'h1) begin
                data_q <= lk.rx_byte;
            end
            if (nbytes_q != 2'h3) begin
                nbytes_q <= nbytes_q + 2'h1;
            end
        end
    end

    // Decoded actions, all but erase_done qualified by the rising chip select.
    assign go         = lk.cs_rise && state_q == ST_CMD;
    assign one_byte   = nbytes_q == 2'h1;
    assign erase_op   = opcode_q == OP_CHIP_ERASE_A ||
                        opcode_q == OP_CHIP_ERASE_B;
    assign erase_go   = go && one_byte && erase_op && wel_q &&
                        bp_q == BP_RESET;
    assign set_go     = go && one_byte && opcode_q == OP_LATCH_SET;
    assign clr_go     = go && one_byte && opcode_q == OP_LATCH_CLEAR;
    assign arm_go     = go && one_byte && opcode_q == OP_STATUS_ARM;
    assign wr_permit  = wp_s_q || !lock_q;
    assign wr_go      = go && nbytes_q[1] && opcode_q == OP_STATUS_WRITE &&
                        (arm_q || wel_q) && wr_permit;
    assign erase_done = busy_q && cnt_q == 32'h0;

    // Arming lasts only until the next frame ends, whatever it was.
    always_ff @(posedge clk) begin
        if (rst) begin
            arm_q <= 1'b0;
        end else if (lk.cs_rise && state_q != ST_IDLE) begin
            arm_q <= arm_go;
        end
    end

    // Write-enable latch.
    always_ff @(posedge clk) begin
        if (rst) begin
            wel_q <= 1'b0;
        end else if (set_go) begin
            wel_q <= 1'b1;
        end else if (clr_go || erase_done || wr_go) begin
            wel_q <= 1'b0;
        end
    end

    // Protection bits; a permitted write may lock and re-level at once.
    always_ff @(posedge clk) begin
        if (rst) begin
            bp_q   <= BP_RESET;
            lock_q <= LOCK_RESET;
        end else if (wr_go) begin
            bp_q   <= data_q[SR_BP_LO +: BP_W];
            lock_q <= data_q[SR_LOCK];
        end
    end

    // Self-timed erase; the array is filled while busy is high.
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q       <= 1'b0;
            cnt_q        <= 32'h0;
            erase_req_q  <= 1'b0;
            erase_fill_q <= ERASED_BYTE;
        end else begin
            erase_req_q  <= erase_go;
            erase_fill_q <= ERASED_BYTE;
            if (erase_go) begin
                busy_q <= 1'b1;
                cnt_q  <= 32'(ERASE_CYCLES - 1);
            end else if (erase_done) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 32'h1;
            end
        end
    end

    // Live status byte.
    always_comb begin
        status_w                       = '0;
        status_w[SR_BUSY]              = busy_q;
        status_w[SR_WEL]               = wel_q;
        status_w[SR_BP_LO +: BP_W]     = bp_q;
        status_w[SR_LOCK]              = lock_q;
    end

    // Status stream: a fresh snapshot at each byte, MSB first on falls.
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_q   <= 3'h7;
            snap_q  <= '0;
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            so_oe_q <= state_d == ST_STREAM;
            if (state_q != ST_STREAM) begin
                idx_q <= 3'h7;
                so_q  <= 1'b0;
            end else if (lk.sck_fall) begin
                idx_q <= idx_q - 3'h1;
                if (idx_q == 3'h7) begin
                    snap_q <= status_w;
                    so_q   <= status_w[SR_W-1];
                end else begin
                    so_q <= snap_q[idx_q];
                end
            end
        end
    end

    // Outputs straight from flip-flops.
    assign so            = so_q;
    assign so_oe         = so_oe_q;
    assign busy          = busy_q;
    assign wel           = wel_q;
    assign protect_level = bp_q;
    assign protect_lock  = lock_q;
    assign erase_req     = erase_req_q;
    assign erase_fill    = erase_fill_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_erase_gated: assert property (
        erase_req_q |-> $past(wel_q) && $past(bp_q) == BP_RESET)
        else $error("Erase started without latch or while protected.");

    chk_erase_frame_end: assert property (
        $rose(busy_q) |-> $past(lk.cs_rise) && erase_req_q)
        else $error("Erase began outside a chip select rise.");

    chk_busy_holds: assert property (
        $rose(busy_q) |-> busy_q [*8])
        else $error("Busy dropped too early.");

    chk_latch_set: assert property (
        set_go |=> wel_q)
        else $error("Latch-set did not set the latch.");

    chk_latch_clear: assert property (
        clr_go |=> !wel_q)
        else $error("Latch-clear did not clear the latch.");

    chk_latch_edge: assert property (
        $changed(wel_q) |-> $past(lk.cs_rise) || $past(erase_done))
        else $error("Latch changed before chip select rose.");

    chk_locked_stable: assert property (
        lock_q && !wp_s_q |=> lock_q && $stable(bp_q))
        else $error("Locked status bits changed while pin low.");

    chk_status_armed: assert property (
        $changed({lock_q, bp_q}) |->
            $past(lk.cs_rise) && ($past(arm_q) || $past(wel_q)))
        else $error("Status bits changed without arming.");

    chk_read_busy: assert property (
        state_q == ST_CMD && nbytes_q == 2'h0 && lk.byte_valid &&
        lk.rx_byte == OP_STATUS_READ |=> state_q == ST_STREAM ##1 so_oe_q)
        else $error("Status read not accepted.");

    chk_stream_msb: assert property (
        state_q == ST_STREAM && lk.sck_fall && idx_q == 3'h7 |=>
            so_q == $past(status_w[SR_W-1]) && so_oe_q)
        else $error("Status stream bit wrong.");

endmodule : sfc_ctrl

`default_nettype wire

// File: design/sfc_pkg.sv
package sfc_pkg;

    // Command opcodes; the erase has two accepted encodings.
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_ARM   = 8'h50;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;

    // Value that every array byte takes after a whole-array erase.
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Status byte layout.
    localparam int SR_W     = 8;
    localparam int SR_BUSY  = 0;
    localparam int SR_WEL   = 1;
    localparam int SR_BP_LO = 2;
    localparam int BP_W     = 3;
    localparam int SR_LOCK  = 7;

    // Values after reset.
    localparam logic [BP_W-1:0] BP_RESET   = 3'h0;
    localparam logic            LOCK_RESET = 1'b0;

    // Clock rate and self-timed durations.
    localparam int unsigned CLK_KHZ      = 50000;
    localparam int unsigned CHIP_ERASE_MS = 8000;
    localparam int unsigned CHIP_ERASE_CYCLES =
        32'(64'(CHIP_ERASE_MS) * 64'(CLK_KHZ));
    localparam int unsigned PWRUP_US     = 10;
    localparam int unsigned PWRUP_CYCLES = PWRUP_US * CLK_KHZ / 1000;
    localparam int          PU_W         = 10;

endpackage : sfc_pkg

// File: design/sfc_link_if.sv
`timescale 1ns/1ns
`default_nettype none

// Byte and frame events passed from the pin sampler to the decoder.
interface sfc_link_if;
    logic       byte_valid;
    logic [7:0] rx_byte;
    logic       cs_fall;
    logic       cs_rise;
    logic       sck_fall;

    modport rx  (output byte_valid, rx_byte, cs_fall, cs_rise, sck_fall);
    modport ctl (input  byte_valid, rx_byte, cs_fall, cs_rise, sck_fall);
endinterface : sfc_link_if

`default_nettype wire

// File: design/sfc_spi_rx.sv
`timescale 1ns/1ns
`default_nettype none

module sfc_spi_rx
    import sfc_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Serial pins.
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    // Events to the decoder.
    sfc_link_if.rx    lk
);

    logic [2:0] sck_q;
    logic [2:0] cs_q;
    logic [1:0] si_q;
    logic [6:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic       sck_rise;
    logic       sel;

    // Two-stage synchronisers; the third stage only serves edge finding.
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_q <= 3'h0;
            cs_q  <= 3'h7;
            si_q  <= 2'h0;
        end else begin
            sck_q <= {sck_q[1:0], sck};
            cs_q  <= {cs_q[1:0], cs_n};
            si_q  <= {si_q[0], si};
        end
    end

    assign sel      = !cs_q[1];
    assign sck_rise = sck_q[1] && !sck_q[2] && sel;

    // Frame edges and falling clock edges as one-cycle pulses.
    always_ff @(posedge clk) begin
        if (rst) begin
            lk.cs_fall  <= 1'b0;
            lk.cs_rise  <= 1'b0;
            lk.sck_fall <= 1'b0;
        end else begin
            lk.cs_fall  <= cs_q[2] && !cs_q[1];
            lk.cs_rise  <= !cs_q[2] && cs_q[1];
            lk.sck_fall <= !sck_q[1] && sck_q[2] && sel;
        end
    end

    // Bits enter MSB first on rising clock edges; eight make a byte.
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q       <= 7'h00;
            bit_cnt_q     <= 3'h0;
            lk.byte_valid <= 1'b0;
            lk.rx_byte    <= 8'h00;
        end else begin
            lk.byte_valid <= 1'b0;
            if (!sel) begin
                bit_cnt_q <= 3'h0;
            end else if (sck_rise) begin
                shift_q   <= {shift_q[5:0], si_q[1]};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    lk.byte_valid <= 1'b1;
                    lk.rx_byte    <= {shift_q, si_q[1]};
                end
            end
        end
    end

    chk_byte_framing: assert property (
        @(posedge clk) disable iff (rst)
        lk.byte_valid |-> $past(bit_cnt_q) == 3'h7 && $past(sck_rise) &&
            $past(sel))
        else $error("Byte delivered without eight clock bits.");

endmodule : sfc_spi_rx

`default_nettype wire

// File: dv/sfc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Serial host: mode 0, link clock of 160 ns that stands low between frames.
module sfc_host_model (
    // Pins driven toward the device.
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    // Pin read back from the device.
    input  wire logic so
);
    // Idle: deselected, clock parked low.
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // Sends nb bytes of dout MSB first, then reads nrd bytes into din.
    task automatic frame(input logic [15:0] dout, input int nb,
                         input int nrd, input int tail,
                         output logic [15:0] din);
        int i;
        din = 16'h0000;
        // Each bit and the whole frame last whole clock periods, so pins keep the caller's phase.
        #20;
        cs_n = 1'b0;
        #80;
        for (i = 0; i < 8 * (nb + nrd); i++) begin
            si = (i < 8 * nb) ? dout[15 - i] : ~si;
            #80 sck = 1'b1;
            #70;
            if (i >= 8 * nb) begin
                din = {din[14:0], so};
            end
            #10 sck = 1'b0;
        end
        #(tail + 80);
        cs_n = 1'b1;
        si   = ~si; // A released line never keeps its last value.
        #200;
    endtask : frame
endmodule : sfc_host_model

`default_nettype wire

// File: dv/serial_flash_status_write_control_tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp, what) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp); \
    end \
end

module serial_flash_status_write_control_tb;
    import sfc_pkg::*;
    localparam int unsigned ERASE_N = 400;

    logic                 clk;
    logic                 rst;
    logic                 wp_n;
    wire logic            cs_n;
    wire logic            sck;
    wire logic            si;
    wire logic            so;
    wire logic            so_oe;
    wire logic            so_line;
    wire logic            busy;
    wire logic            wel;
    wire logic            protect_lock;
    wire logic            erase_req;
    wire logic [BP_W-1:0] protect_level;
    wire logic [7:0]      erase_fill;
    int                   miscompares;
    int                   checks_done;
    int                   cycles;
    int                   erase_seen;
    int                   m_wel, m_bp, m_lock, m_busy, m_arm, m_erases;
    int                   pwr_ok, k, n;
    logic [31:0]          lfsr_q;
    logic [15:0]          rd;

    sfc_ctrl #(.ERASE_CYCLES(ERASE_N)) dut (
        .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy), .wel(wel),
        .protect_level(protect_level), .protect_lock(protect_lock),
        .erase_req(erase_req), .erase_fill(erase_fill)
    );

    // A released data line shows the inverse of the device's so output.
    assign so_line = so_oe ? so : ~so;

    sfc_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so_line));

    // The 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Counts erase start pulses and cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (erase_req === 1'b1) begin
            erase_seen++;
        end
        if (cycles == 60000) begin
            miscompares++;
            $display("ERROR t=%0t run did not finish", $time);
            stop_test();
        end
    end

    // Pseudo-random sequence for status write data and pin levels.
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Reference model: applies one finished frame to the state.
    task automatic model_apply(input logic [7:0] op, input logic [7:0] dat,
                               input int nb);
        int was_arm;
        was_arm = m_arm;
        m_arm   = 0;
        if (pwr_ok == 0 || m_busy != 0) begin
            return;
        end
        case (op)
            OP_LATCH_SET:    m_wel = 1;
            OP_LATCH_CLEAR:  m_wel = 0;
            OP_STATUS_ARM:   m_arm = 1;
            OP_STATUS_WRITE: begin
                if (nb == 2 && (was_arm != 0 || m_wel != 0) &&
                    !(wp_n == 1'b0 && m_lock != 0)) begin
                    m_lock = dat[7];
                    m_bp   = dat[4:2];
                    m_wel  = 0;
                end
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                if (m_wel != 0 && m_bp == 0) begin
                    m_busy = 1;
                    m_erases++;
                end
            end
            default: ;
        endcase
    endtask : model_apply

    // Compares the status outputs with the model.
    task automatic check_status();
        `CHK(wel, 1'(m_wel), "latch")
        `CHK(protect_level, 3'(m_bp), "level")
        `CHK(protect_lock, 1'(m_lock), "lock")
        `CHK(busy, 1'(m_busy), "busy")
        `CHK(erase_seen, m_erases, "erase starts")
    endtask : check_status

    // One command frame, then model update and comparison.
    task automatic cmd(input logic [7:0] op, input logic [7:0] dat,
                       input int nb);
        host.frame({op, dat}, nb, 0, 0, rd);
        model_apply(op, dat, nb);
        check_status();
    endtask : cmd

    // Reads the status byte twice in one frame.
    task automatic read_status();
        logic [7:0] e;
        host.frame({OP_STATUS_READ, 8'h00}, 1, 2, 0, rd);
        m_arm = 0;
        e = 8'((m_lock << SR_LOCK) | (m_bp << SR_BP_LO) |
               (m_wel << SR_WEL) | (m_busy << SR_BUSY));
        `CHK(rd & 16'h9f9f, {e, e}, "status")
        `CHK(so_oe, 1'b0, "so released")
    endtask : read_status

    // Status write preceded by one frame with opcode pre (arm, latch set or status read), pin set first.
    task automatic sw(input logic [7:0] pre, input logic wp,
                      input logic [7:0] dat);
        wp_n = wp;
        cmd(pre, 8'h00, 1);
        cmd(OP_STATUS_WRITE, dat, 2);
    endtask : sw

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // Main sequence.
    initial begin
        rst    = 1'b1;
        wp_n   = 1'b1;
        lfsr_q = 32'h526f8c08;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        cmd(OP_LATCH_SET, 8'h00, 1);
        repeat (PWRUP_CYCLES) @(negedge clk);
        pwr_ok = 1;
        // Latch set with chip select held low long after the opcode.
        fork
            host.frame({OP_LATCH_SET, 8'h00}, 1, 0, 400, rd);
            begin
                #1500;
                `CHK(wel, 1'b0, "early latch")
            end
        join
        model_apply(OP_LATCH_SET, 8'h00, 1);
        check_status();
        cmd(OP_LATCH_CLEAR, 8'h00, 1);
        // Arming lost when another frame comes between.
        cmd(OP_STATUS_ARM, 8'h00, 1);
        read_status();
        cmd(OP_STATUS_WRITE, 8'h9c, 2);
        sw(OP_STATUS_ARM, 1'b1, 8'h9c);
        cmd(OP_LATCH_SET, 8'h00, 1);
        cmd(OP_CHIP_ERASE_A, 8'h00, 1);
        cmd(OP_LATCH_CLEAR, 8'h00, 1);
        sw(OP_STATUS_ARM, 1'b0, 8'h00);
        sw(OP_STATUS_ARM, 1'b1, 8'h00);
        sw(OP_LATCH_SET, 1'b0, 8'h88);
        for (k = 0; k < 8; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            sw(lfsr_q[1] ? OP_STATUS_ARM :
               (lfsr_q[2] ? OP_LATCH_SET : OP_STATUS_READ),
               lfsr_q[0], lfsr_q[15:8]);
        end
        sw(OP_STATUS_ARM, 1'b1, 8'h00);
        cmd(OP_CHIP_ERASE_B, 8'h00, 1);
        // Both erase opcodes, busy polled on the busy output and read in the status byte.
        for (k = 0; k < 2; k++) begin
            cmd(OP_LATCH_SET, 8'h00, 1);
            cmd(k == 0 ? OP_CHIP_ERASE_A : OP_CHIP_ERASE_B, 8'h00, 1);
            `CHK(erase_fill, ERASED_BYTE, "fill")
            read_status();
            n = 0;
            while (busy !== 1'b0 && n < 1000) begin
                @(negedge clk);
                n++;
            end
            repeat (2) @(negedge clk);
            m_busy = 0;
            m_wel  = 0;
            check_status();
            read_status();
        end
        stop_test();
    end
endmodule : serial_flash_status_write_control_tb

`default_nettype wire
